/* test/pcdb_clock_bank_props.sv */
`timescale 1ns/1ps
`include "pcdb_defs.svh"
// ****
// port checker
// ****
module pcdb_clock_bank_props
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // sources and register port
  input wire logic ref_tick,
  input wire logic pll_tick,
  input wire logic [15:0] reg_addr,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  // divided outputs
  input wire logic prescaler_tick,
  input wire logic system_clock_one,
  input wire logic system_clock_two,
  input wire logic system_clock_three,
  input wire logic sys1_tick,
  input wire logic sys2_tick,
  input wire logic sys3_tick,
  input wire logic aux_tick,
  input wire logic aux_clock_output
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  rdata_idle_a:
    assert property (!$past(reg_read) |-> reg_rdata == 16'h0000) else $error("read data outside answer cycle");
  rsvd_zero_a:
    assert property (reg_read |=> reg_rdata[14:5] == 10'h000) else $error("reserved bits read nonzero");
  sys_codes_a:
    assert property (reg_read && reg_addr inside {`PCDB_OFF_SYS1, `PCDB_OFF_SYS2, `PCDB_OFF_SYS3}
      |=> reg_rdata[4:0] inside {5'h00, 5'h01, 5'h03}) else $error("reserved ratio stored");
  one_level_a:
    assert property (sys1_tick |-> system_clock_one) else $error("clock one low at tick");
  two_level_a:
    assert property (sys2_tick |-> system_clock_two) else $error("clock two low at tick");
  three_level_a:
    assert property (sys3_tick |-> system_clock_three) else $error("clock three low at tick");
  sys_source_a:
    assert property (sys1_tick |-> $past(ref_tick) || $past(pll_tick)) else $error("tick without source");
  pre_source_a:
    assert property (prescaler_tick |-> $past(ref_tick)) else $error("prescaler tick without reference");
  aux_source_a:
    assert property (aux_tick |-> $past(ref_tick)) else $error("aux tick without oscillator");
  aux_level_a:
    assert property (aux_tick |-> aux_clock_output) else $error("aux clock low at tick");
  cover property (sys1_tick ##2 sys1_tick);
  cover property (aux_tick);
  cover property (reg_read && reg_addr == `PCDB_OFF_SYS2);
endmodule

bind pcdb_clock_bank pcdb_clock_bank_props props (.clock(clock), .reset_n(reset_n), .ref_tick(ref_tick),
  .pll_tick(pll_tick), .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .prescaler_tick(prescaler_tick), .system_clock_one(system_clock_one), .system_clock_two(system_clock_two),
  .system_clock_three(system_clock_three), .sys1_tick(sys1_tick), .sys2_tick(sys2_tick),
  .sys3_tick(sys3_tick), .aux_tick(aux_tick), .aux_clock_output(aux_clock_output));

/* test/pcdb_clock_bank_tb_top.sv */
`timescale 1ns/1ps
`include "pcdb_defs.svh"
module pcdb_clock_bank_tb_top;
  logic clock;
  logic reset_n;
  logic ref_tick;
  logic pll_tick;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_write, reg_read, prescaler_tick, aux_clock_output, aux_tick;
  logic system_clock_one, system_clock_two, system_clock_three, sys1_tick, sys2_tick, sys3_tick;
  logic [4:0] tk;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  int cs [3] = '{0, 1, 3};
  assign tk = {aux_tick, sys3_tick, sys2_tick, sys1_tick, prescaler_tick};

  pcdb_clock_bank dut (.clock(clock), .reset_n(reset_n), .ref_tick(ref_tick), .pll_tick(pll_tick),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .prescaler_tick(prescaler_tick), .system_clock_one(system_clock_one),
    .system_clock_two(system_clock_two), .system_clock_three(system_clock_three), .sys1_tick(sys1_tick),
    .sys2_tick(sys2_tick), .sys3_tick(sys3_tick), .aux_clock_output(aux_clock_output), .aux_tick(aux_tick));

  // ****
  // clock, timeout and helpers
  // ****
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // the whole sequence needs well under a thousand cycles
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_fail = n_fail + 1;
      report_and_stop();
    end
  end

  task report_and_stop();
    if (n_fail == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task check(string nm, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wr(logic [15:0] a, logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task rd(logic [15:0] a, logic [15:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    check("reg_rdata", reg_rdata, e);
  endtask

  // waits for one tick, then counts cycles to the next; the bound stops a dead divider hanging here
  task gap(int i, int e);
    int n;
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      do
      begin
        @(posedge clock);
        #1;
        n++;
      end while (tk[i] !== 1'b1 && n < 100);
    end
    check("tick gap", n[15:0], e[15:0]);
  endtask

  task cnt(int i, int e);
    int n;
    n = 0;
    repeat (40)
    begin
      @(posedge clock);
      #1;
      if (tk[i] === 1'b1)
        n++;
    end
    check("tick count", n[15:0], e[15:0]);
  endtask

  // ****
  // sequence
  // ****
  initial
  begin
    reset_n = 1'b0;
    ref_tick = 1'b1;
    pll_tick = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    rd(`PCDB_OFF_SYS1, 16'h8003);
    rd(`PCDB_OFF_SYS2, 16'h8003);
    rd(`PCDB_OFF_SYS3, 16'h8003);
    rd(`PCDB_OFF_PRESCALER, 16'h8000);
    rd(`PCDB_OFF_AUX, 16'h0000);
    rd(16'h1C94, 16'h0000);
    gap(1, 4);
    wr(`PCDB_OFF_SYS1, 16'hFFE1);
    rd(`PCDB_OFF_SYS1, 16'h8001);
    gap(1, 2);
    wr(`PCDB_OFF_SYS1, 16'h8002);
    rd(`PCDB_OFF_SYS1, 16'h8001);
    gap(1, 2);
    foreach (cs[j])
    begin
      wr(`PCDB_OFF_SYS2, 16'h8000 | cs[j][15:0]);
      gap(2, cs[j] + 1);
      wr(`PCDB_OFF_SYS3, 16'h8000 | cs[j][15:0]);
      gap(3, cs[j] + 1);
    end
    wr(`PCDB_OFF_SYS1, 16'h0001);
    cnt(1, 0);
    check("system_clock_one", {15'h0000, system_clock_one}, 16'h0000);
    wr(`PCDB_OFF_SYS1, 16'h8000);
    gap(1, 1);
    wr(`PCDB_OFF_PRESCALER, 16'h801F);
    gap(0, 32);
    wr(`PCDB_OFF_PRESCALER, 16'h001F);
    cnt(0, 0);
    check("aux_clock_output", {15'h0000, aux_clock_output}, 16'h0000);
    wr(`PCDB_OFF_AUX, 16'h8004);
    gap(4, 5);
    @(posedge clock);
    ref_tick <= 1'b0;
    pll_tick <= 1'b1;
    cnt(1, 0);
    wr(`PCDB_OFF_PLL_CTRL, 16'h0001);
    cnt(4, 0);
    gap(1, 1);
    report_and_stop();
  end
endmodule

/* verilog/pcdb_clock_bank.sv */
// Function
// R1: prescaler 5-bit ratio, n divides n+1
// R2: first divider makes system clock one
// R3: divider one enable bit 15, reset 1
// R4: divider one codes 1,2,4; reset 00011
// R5: second divider makes system clock two
// R6: divider two enable bit 15, reset 1
// R7: divider two codes 1,2,4; reset 00011
// R8: third divider makes system clock three
// R9: divider three enable bit 15, reset 1
// R10: divider three codes 1,2,4; reset 00011
// R11: bits 14:5 read zero, writes ignored
// R12: software avoids reserved post-divider codes
// R13: aux divider fed from oscillator only
// R14: bypass skips prescaler and pll
// R15: prescaler enable bit 15, reset 1
// R16: disabled holds static; change at boundary
// R17: reserved code keeps previous valid ratio
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "pcdb_defs.svh"

module pcdb_clock_bank
#(
  parameter int RATIO_W = 5
)
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // clock sources as one-cycle ticks
  input wire logic ref_tick,
  input wire logic pll_tick,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // prescaler output towards the pll
  output logic prescaler_tick,
  // system clocks as enable pulses and levels
  output logic system_clock_one,
  output logic system_clock_two,
  output logic system_clock_three,
  output logic sys1_tick,
  output logic sys2_tick,
  output logic sys3_tick,
  // auxiliary output
  output logic aux_clock_output,
  output logic aux_tick
);

  typedef struct packed
  {
    pcdb_pkg::pcdb_ratio_t prescaler_ratio;
    logic prescaler_enable;
    pcdb_pkg::pcdb_ratio_t sys1_div_ratio;
    logic sys1_div_enable;
    pcdb_pkg::pcdb_ratio_t sys2_div_ratio;
    logic sys2_div_enable;
    pcdb_pkg::pcdb_ratio_t sys3_div_ratio;
    logic sys3_div_enable;
    pcdb_pkg::pcdb_ratio_t aux_osc_divider;
    logic aux_osc_enable;
    pcdb_pkg::pcdb_path_t pll_path_select;
    logic [15:0] rdata;
  } pcdb_bank_state_t;

  pcdb_bank_state_t state;
  pcdb_bank_state_t next_state;
  logic post_src_tick;

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic pcdb_code_ok(input logic [4:0] code);
    pcdb_code_ok = (code == `PCDB_CODE_DIV1) || (code == `PCDB_CODE_DIV2) || (code == `PCDB_CODE_DIV4);
  endfunction

  function automatic logic [15:0] pcdb_pack(input logic en, input logic [4:0] ratio);
    logic [15:0] word;
    word = '0;
    word[`PCDB_ENABLE_BIT] = en;
    word[`PCDB_RATIO_MSB:0] = ratio;
    pcdb_pack = word; // see R11
  endfunction

  // ***************************************************************
  // register file
  // ***************************************************************
  always_comb
  begin
    next_state = state;
    if (reg_write)
    begin
      case (reg_addr)
        `PCDB_OFF_PLL_CTRL:
        begin
          next_state.pll_path_select = pcdb_pkg::pcdb_path_t'(reg_wdata[`PCDB_PATH_BIT]);
        end
        `PCDB_OFF_PRESCALER:
        begin
          next_state.prescaler_enable = reg_wdata[`PCDB_ENABLE_BIT]; // see R15
          next_state.prescaler_ratio = reg_wdata[`PCDB_RATIO_MSB:0]; // see R1
        end
        `PCDB_OFF_SYS1:
        begin
          next_state.sys1_div_enable = reg_wdata[`PCDB_ENABLE_BIT]; // see R3
          if (pcdb_code_ok(reg_wdata[`PCDB_RATIO_MSB:0]))
          begin
            // reserved codes are dropped, the old ratio stays, see R17
            next_state.sys1_div_ratio = reg_wdata[`PCDB_RATIO_MSB:0]; // see R4
          end
        end
        `PCDB_OFF_SYS2:
        begin
          next_state.sys2_div_enable = reg_wdata[`PCDB_ENABLE_BIT]; // see R6
          if (pcdb_code_ok(reg_wdata[`PCDB_RATIO_MSB:0]))
          begin
            next_state.sys2_div_ratio = reg_wdata[`PCDB_RATIO_MSB:0]; // see R7
          end
        end
        `PCDB_OFF_SYS3:
        begin
          next_state.sys3_div_enable = reg_wdata[`PCDB_ENABLE_BIT]; // see R9
          if (pcdb_code_ok(reg_wdata[`PCDB_RATIO_MSB:0]))
          begin
            next_state.sys3_div_ratio = reg_wdata[`PCDB_RATIO_MSB:0]; // see R10
          end
        end
        `PCDB_OFF_AUX:
        begin
          next_state.aux_osc_enable = reg_wdata[`PCDB_ENABLE_BIT];
          next_state.aux_osc_divider = reg_wdata[`PCDB_RATIO_MSB:0];
        end
        default:
        begin
          next_state.rdata = state.rdata;
        end
      endcase
    end
    next_state.rdata = '0;
    if (reg_read)
    begin
      case (reg_addr)
        `PCDB_OFF_PLL_CTRL:
        begin
          next_state.rdata = {15'h0000, state.pll_path_select};
        end
        `PCDB_OFF_PRESCALER:
        begin
          next_state.rdata = pcdb_pack(state.prescaler_enable, state.prescaler_ratio);
        end
        `PCDB_OFF_SYS1:
        begin
          next_state.rdata = pcdb_pack(state.sys1_div_enable, state.sys1_div_ratio); // see R11
        end
        `PCDB_OFF_SYS2:
        begin
          next_state.rdata = pcdb_pack(state.sys2_div_enable, state.sys2_div_ratio);
        end
        `PCDB_OFF_SYS3:
        begin
          next_state.rdata = pcdb_pack(state.sys3_div_enable, state.sys3_div_ratio);
        end
        `PCDB_OFF_AUX:
        begin
          next_state.rdata = pcdb_pack(state.aux_osc_enable, state.aux_osc_divider);
        end
        default:
        begin
          next_state.rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state.prescaler_ratio <= `PCDB_RST_PRE_RATIO; // see R1
      state.prescaler_enable <= `PCDB_RST_PRE_EN; // see R15
      state.sys1_div_ratio <= `PCDB_RST_SYS_RATIO; // see R4
      state.sys1_div_enable <= `PCDB_RST_SYS_EN; // see R3
      state.sys2_div_ratio <= `PCDB_RST_SYS_RATIO; // see R7
      state.sys2_div_enable <= `PCDB_RST_SYS_EN; // see R6
      state.sys3_div_ratio <= `PCDB_RST_SYS_RATIO; // see R10
      state.sys3_div_enable <= `PCDB_RST_SYS_EN; // see R9
      state.aux_osc_divider <= `PCDB_RST_AUX_RATIO;
      state.aux_osc_enable <= `PCDB_RST_AUX_EN;
      state.pll_path_select <= pcdb_pkg::PCDB_PATH_BYPASS;
      state.rdata <= 16'h0000;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;

  // ***************************************************************
  // clock path
  // ***************************************************************
  // prescaler feeds the pll reference; the pll itself lives outside
  pcdb_divider #(.RATIO_W(RATIO_W)) u_prescaler
  (
    .clock(clock),
    .reset_n(reset_n),
    .tick_in(ref_tick),
    .enable(state.prescaler_enable),
    .ratio(state.prescaler_ratio),
    .tick_out(prescaler_tick),
    // the pll only needs the tick, the level has no consumer here
    .clk_level()
  );

  // bypass takes the reference straight, skipping prescaler and pll, see R14
  assign post_src_tick = (state.pll_path_select == pcdb_pkg::PCDB_PATH_PLL) ? pll_tick : ref_tick;

  // the three post-dividers share one source in either mode, see R2
  pcdb_divider #(.RATIO_W(RATIO_W)) u_sys1
  (
    .clock(clock),
    .reset_n(reset_n),
    .tick_in(post_src_tick),
    .enable(state.sys1_div_enable),
    .ratio(state.sys1_div_ratio),
    .tick_out(sys1_tick),
    .clk_level(system_clock_one)
  );

  pcdb_divider #(.RATIO_W(RATIO_W)) u_sys2 // see R5
  (
    .clock(clock),
    .reset_n(reset_n),
    .tick_in(post_src_tick),
    .enable(state.sys2_div_enable),
    .ratio(state.sys2_div_ratio),
    .tick_out(sys2_tick),
    .clk_level(system_clock_two)
  );

  pcdb_divider #(.RATIO_W(RATIO_W)) u_sys3 // see R8
  (
    .clock(clock),
    .reset_n(reset_n),
    .tick_in(post_src_tick),
    .enable(state.sys3_div_enable),
    .ratio(state.sys3_div_ratio),
    .tick_out(sys3_tick),
    .clk_level(system_clock_three)
  );

  // aux divider never sees the pll output, see R13
  pcdb_divider #(.RATIO_W(RATIO_W)) u_aux
  (
    .clock(clock),
    .reset_n(reset_n),
    .tick_in(ref_tick),
    .enable(state.aux_osc_enable),
    .ratio(state.aux_osc_divider),
    .tick_out(aux_tick),
    .clk_level(aux_clock_output)
  );

endmodule

/* verilog/pcdb_defs.svh */
`ifndef PCDB_DEFS_SVH
`define PCDB_DEFS_SVH

// ***************************************************************
// register offsets (16-bit word addresses on the plain port)
// ***************************************************************
`define PCDB_OFF_PLL_CTRL 16'h1C86
`define PCDB_OFF_PRESCALER 16'h1C8A
`define PCDB_OFF_SYS1 16'h1C8C
`define PCDB_OFF_SYS2 16'h1C8E
`define PCDB_OFF_SYS3 16'h1C90
`define PCDB_OFF_AUX 16'h1C92

// ***************************************************************
// field positions
// ***************************************************************
`define PCDB_ENABLE_BIT 15
`define PCDB_RATIO_MSB 4
`define PCDB_PATH_BIT 0

// ***************************************************************
// reset values
// ***************************************************************
`define PCDB_RST_PRE_RATIO 5'h00
`define PCDB_RST_PRE_EN 1'b1
`define PCDB_RST_SYS_RATIO 5'h03
`define PCDB_RST_SYS_EN 1'b1
`define PCDB_RST_AUX_RATIO 5'h00
`define PCDB_RST_AUX_EN 1'b0
`define PCDB_RST_PATH 1'b0

// ***************************************************************
// post-divider ratio codes
// ***************************************************************
`define PCDB_CODE_DIV1 5'h00
`define PCDB_CODE_DIV2 5'h01
`define PCDB_CODE_DIV4 5'h03

`endif

/* verilog/pcdb_divider.sv */
`timescale 1ns/1ps
`include "pcdb_defs.svh"

module pcdb_divider
#(
  parameter int RATIO_W = 5
)
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // source tick
  input wire logic tick_in,
  // control
  input wire logic enable,
  input wire logic [RATIO_W-1:0] ratio,
  // divided output
  output logic tick_out,
  output logic clk_level
);

  typedef struct packed
  {
    logic [RATIO_W-1:0] count;
    logic [RATIO_W-1:0] active;
    logic tick;
    logic level;
  } pcdb_div_state_t;

  pcdb_div_state_t state;
  pcdb_div_state_t next_state;

  // ***************************************************************
  // counter: terminal count is ratio, so n divides by n+1
  // ***************************************************************
  always_comb
  begin
    next_state = state;
    next_state.tick = 1'b0;
    if (!enable)
    begin
      // disabled output rests low, counter parked at a boundary
      next_state.count = '0;
      next_state.level = 1'b0;
      next_state.active = ratio;
    end
    else if (tick_in)
    begin
      if (state.count >= state.active)
      begin
        next_state.count = '0;
        next_state.tick = 1'b1;
        // new ratio loaded at the period boundary, or every cycle while disabled, see R16
        next_state.active = ratio;
        next_state.level = 1'b1;
      end
      else
      begin
        next_state.count = state.count + 1'b1;
        if (state.count == (state.active >> 1))
        begin
          next_state.level = 1'b0;
        end
      end
      if (state.active == '0)
      begin
        // divide by one follows the source tick
        next_state.level = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign tick_out = state.tick;
  assign clk_level = state.level;

endmodule

/* verilog/pcdb_pkg.sv */
package pcdb_pkg;

  typedef logic [4:0] pcdb_ratio_t;

  typedef enum logic [0:0]
  {
    PCDB_PATH_BYPASS = 1'b0,
    PCDB_PATH_PLL = 1'b1
  } pcdb_path_t;

endpackage
